// File: logic/tla_alarm_regs.sv
// Register set and limit comparators of a local/remote temperature sensor.
// Assumes a serial engine issues command-byte reads and writes on the core clock.
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
module tla_alarm_regs #(
  parameter int BASE_CYCLES = tla_pkg::FAST_CYCLES
) (
  input wire logic mclk_in, // Core clock, 100 MHz
  input wire logic rstn_in, // Async reset, low
  input wire logic wr_en_in, // Register write strobe
  input wire logic rd_en_in, // Register read strobe
  input wire logic [7:0] cmd_in, // Command byte
  input wire logic [7:0] wdata_in, // Write data
  input wire logic conv_done_in, // Conversion result valid
  input wire logic [10:0] local_temp_in, // Local reading, 0.125 C
  input wire logic [10:0] remote_raw_in, // Raw remote reading, 0.125 C
  input wire logic diode_open_in, // Remote diode disconnected
  input wire logic conv_busy_in, // Converter busy
  output logic [7:0] rdata_out, // Read data
  output logic rvalid_out, // Read data valid pulse
  output logic conv_start_out, // Start conversion pulse
  output logic [10:0] remote_temp_out, // Offset-corrected remote reading
  output logic alert_req_out, // Alert interrupt request
  output logic overheat_output_out // Critical output, high active
);
  // Register file, alarm state and synchronisers in one record
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] status;
    logic [3:0] rate;
    logic [7:0] loc_hi;
    logic [7:0] loc_lo;
    logic [7:0] rem_hi_h;
    logic [7:0] rem_hi_l;
    logic [7:0] rem_lo_h;
    logic [7:0] rem_lo_l;
    logic [7:0] ofs_h;
    logic [7:0] ofs_l;
    logic [7:0] rem_crit;
    logic [7:0] loc_crit;
    logic [4:0] hyst;
    logic local_critical_flag_act;
    logic remote_critical_flag_act;
    logic [10:0] rem_temp;
    logic [7:0] rdata;
    logic rvalid;
    logic alert;
    logic overheat;
    logic [1:0] busy_sync;
    logic [1:0] open_sync;
  } tla_regs_s;
  tla_regs_s st_ff, nxt_st;

  // The interval timer needs a base of at least two cycles
  if (BASE_CYCLES < 2) begin : g_bad_base
    $error("BASE_CYCLES too small");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interval timer and remote qualifiers
  logic tick;
  logic signed [11:0] rem_sum;
  logic signed [10:0] rem_corr;
  logic signed [10:0] loc_t;
  logic signed [10:0] rem_hi_lim;
  logic signed [10:0] rem_lo_lim;
  logic signed [10:0] rem_crit_lim;
  logic signed [10:0] loc_hi_lim;
  logic signed [10:0] loc_lo_lim;
  logic signed [10:0] loc_crit_lim;
  logic signed [10:0] loc_rel_lim;
  logic signed [10:0] rem_rel_lim;
  logic rem_hi_hit;
  logic rem_lo_hit;
  logic rem_crit_hit;
  logic loc_hi_hit;
  logic loc_lo_hit;
  logic loc_crit_hit;

  // One start pulse per conversion interval
  tla_rate_timer #(.BASE_CYCLES(BASE_CYCLES)) u_timer (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .rate_in(st_ff.rate),
    .tick_out(tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Helpers
  // Whole-degree byte widened to 0.125 degree steps
  function automatic logic signed [10:0] deg_to_fix(input logic [7:0] b);
    deg_to_fix = {b, 3'b000};
  endfunction

  // Clamp to the 11-bit reading range; a wrapped value would flip an alarm
  function automatic logic signed [10:0] sat11(input logic signed [11:0] v);
    if (v > 12'sh3FF) begin
      sat11 = 11'sh3FF;
    end else if (v < -12'sh400) begin
      sat11 = 11'sh400;
    end else begin
      sat11 = v[10:0];
    end
  endfunction

  // Release point saturates so a very low critical limit cannot wrap positive
  function automatic logic signed [10:0] rel_limit(input logic [7:0] crit, input logic [4:0] hyst);
    logic signed [11:0] diff;
    diff = 12'(signed'({crit, 3'b000})) - 12'(signed'({4'h0, hyst, 3'b000}));
    rel_limit = sat11(diff);
  endfunction

  // Read multiplexer; unmapped and write-only commands read as zero
  function automatic logic [7:0] read_reg(input tla_regs_s s, input logic [7:0] cmd);
    unique case (cmd)
      tla_pkg::RD_STATUS: read_reg = {s.busy_sync[1], s.status[6:0]};
      tla_pkg::RD_CONFIG: read_reg = s.cfg & tla_pkg::CFG_MASK;
      tla_pkg::RD_RATE: read_reg = {4'h0, s.rate};
      tla_pkg::RD_LOC_HI: read_reg = s.loc_hi;
      tla_pkg::RD_REM_HI_H: read_reg = s.rem_hi_h;
      tla_pkg::RW_REM_HI_L: read_reg = s.rem_hi_l;
      tla_pkg::RD_LOC_LO: read_reg = s.loc_lo;
      tla_pkg::RD_REM_LO_H: read_reg = s.rem_lo_h;
      tla_pkg::RW_REM_LO_L: read_reg = s.rem_lo_l;
      tla_pkg::RW_OFS_H: read_reg = s.ofs_h;
      tla_pkg::RW_OFS_L: read_reg = s.ofs_l;
      tla_pkg::RW_REM_CRIT: read_reg = s.rem_crit;
      tla_pkg::RW_LOC_CRIT: read_reg = s.loc_crit;
      tla_pkg::RW_HYST: read_reg = {3'h0, s.hyst};
      default: read_reg = 8'h00;
    endcase
  endfunction

  always_comb begin
    rem_sum = 12'(signed'(remote_raw_in)) + 12'(signed'({st_ff.ofs_h, st_ff.ofs_l[7:5]}));
    rem_corr = sat11(rem_sum);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Limits and comparisons
  always_comb begin
    loc_t = signed'(local_temp_in);
    loc_hi_lim = deg_to_fix(st_ff.loc_hi);
    loc_lo_lim = deg_to_fix(st_ff.loc_lo);
    loc_crit_lim = deg_to_fix(st_ff.loc_crit);
    rem_crit_lim = deg_to_fix(st_ff.rem_crit);
    rem_hi_lim = signed'({st_ff.rem_hi_h, st_ff.rem_hi_l[7:5]});
    rem_lo_lim = signed'({st_ff.rem_lo_h, st_ff.rem_lo_l[7:5]});
    loc_rel_lim = rel_limit(st_ff.loc_crit, st_ff.hyst);
    rem_rel_lim = rel_limit(st_ff.rem_crit, st_ff.hyst);
    loc_hi_hit = loc_t > loc_hi_lim;
    loc_lo_hit = loc_t < loc_lo_lim;
    loc_crit_hit = loc_t > loc_crit_lim;
  end

  // Only the remote channel passes through the fault queue
  tla_fault_queue u_q_hi (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .sample_in(conv_done_in),
    .over_in(rem_corr > rem_hi_lim),
    .queue_in(st_ff.cfg[tla_pkg::CFG_FAULTQ]),
    .hit_out(rem_hi_hit)
  );
  tla_fault_queue u_q_lo (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .sample_in(conv_done_in),
    .over_in(rem_corr < rem_lo_lim),
    .queue_in(st_ff.cfg[tla_pkg::CFG_FAULTQ]),
    .hit_out(rem_lo_hit)
  );
  tla_fault_queue u_q_crit (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .sample_in(conv_done_in),
    .over_in(rem_corr > rem_crit_lim),
    .queue_in(st_ff.cfg[tla_pkg::CFG_FAULTQ]),
    .hit_out(rem_crit_hit)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Register file and alarm state
  logic [7:0] set_bits;
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rvalid = 1'b0;
    // Busy and open pins are asynchronous: two stages before any use
    nxt_st.busy_sync = {st_ff.busy_sync[0], conv_busy_in};
    nxt_st.open_sync = {st_ff.open_sync[0], diode_open_in};
    set_bits = 8'h00;
    if (conv_done_in) begin
      nxt_st.rem_temp = rem_corr;
      set_bits[tla_pkg::ST_LOCAL_OVER_LIMIT_FLAG] = loc_hi_hit;
      set_bits[tla_pkg::ST_LOCAL_UNDER_LIMIT_FLAG] = loc_lo_hit;
      set_bits[tla_pkg::ST_REMOTE_OVER_LIMIT_FLAG] = rem_hi_hit;
      set_bits[tla_pkg::ST_REMOTE_UNDER_LIMIT_FLAG] = rem_lo_hit;
      set_bits[tla_pkg::ST_REMOTE_CRITICAL_FLAG] = rem_crit_hit;
      set_bits[tla_pkg::ST_LOCAL_CRITICAL_FLAG] = loc_crit_hit;
      if (loc_crit_hit) begin
        nxt_st.local_critical_flag_act = 1'b1;
      end else if (loc_t < loc_rel_lim) begin
        nxt_st.local_critical_flag_act = 1'b0;
      end
      if (rem_crit_hit) begin
        nxt_st.remote_critical_flag_act = 1'b1;
      end else if (rem_corr < rem_rel_lim) begin
        nxt_st.remote_critical_flag_act = 1'b0;
      end
    end
    set_bits[tla_pkg::ST_OPEN] = st_ff.open_sync[1];
    if (rd_en_in) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = read_reg(st_ff, cmd_in);
    end
    // Read clears latched alarms; a same-cycle event survives
    if (rd_en_in && cmd_in == tla_pkg::RD_STATUS) begin
      nxt_st.status = set_bits;
    end else begin
      nxt_st.status = st_ff.status | set_bits;
    end
    // Busy is shown live on read, so the latched copy stays clear
    nxt_st.status[tla_pkg::ST_BUSY] = 1'b0;
    // Writes to read-only addresses fall to the default and are dropped
    if (wr_en_in) begin
      unique case (cmd_in)
        tla_pkg::WR_CONFIG: nxt_st.cfg = wdata_in & tla_pkg::CFG_MASK;
        tla_pkg::WR_RATE: nxt_st.rate = wdata_in[3:0];
        tla_pkg::WR_LOC_HI: nxt_st.loc_hi = wdata_in;
        tla_pkg::WR_REM_HI_H: nxt_st.rem_hi_h = wdata_in;
        tla_pkg::RW_REM_HI_L: nxt_st.rem_hi_l = wdata_in & tla_pkg::FRAC_MASK;
        tla_pkg::WR_LOC_LO: nxt_st.loc_lo = wdata_in;
        tla_pkg::WR_REM_LO_H: nxt_st.rem_lo_h = wdata_in;
        tla_pkg::RW_REM_LO_L: nxt_st.rem_lo_l = wdata_in & tla_pkg::FRAC_MASK;
        tla_pkg::RW_OFS_H: nxt_st.ofs_h = wdata_in;
        tla_pkg::RW_OFS_L: nxt_st.ofs_l = wdata_in & tla_pkg::FRAC_MASK;
        tla_pkg::RW_REM_CRIT: nxt_st.rem_crit = wdata_in;
        tla_pkg::RW_LOC_CRIT: nxt_st.loc_crit = wdata_in;
        tla_pkg::RW_HYST: nxt_st.hyst = wdata_in[4:0] & tla_pkg::HYST_MASK[4:0];
        default: ;
      endcase
    end
    nxt_st.alert = |(nxt_st.status & tla_pkg::ALERT_BITS);
    // Critical status latches even when masked; the mask only gates the pin
    nxt_st.overheat = (nxt_st.local_critical_flag_act && !nxt_st.cfg[tla_pkg::CFG_LOCAL_CRITICAL_FLAG_MASK]) ||
      (nxt_st.remote_critical_flag_act && !nxt_st.cfg[tla_pkg::CFG_REMOTE_CRITICAL_FLAG_MASK]);
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      // Status and config come up clear, limits at their defaults
      st_ff <= '0;
      st_ff.rate <= tla_pkg::RST_RATE[3:0];
      st_ff.loc_hi <= tla_pkg::RST_UPPER;
      st_ff.rem_hi_h <= tla_pkg::RST_UPPER;
      st_ff.rem_hi_l <= tla_pkg::RST_ZERO;
      st_ff.loc_lo <= tla_pkg::RST_ZERO;
      st_ff.rem_lo_h <= tla_pkg::RST_ZERO;
      st_ff.rem_lo_l <= tla_pkg::RST_ZERO;
      st_ff.ofs_h <= tla_pkg::RST_ZERO;
      st_ff.ofs_l <= tla_pkg::RST_ZERO;
      st_ff.rem_crit <= tla_pkg::RST_CRIT;
      st_ff.loc_crit <= tla_pkg::RST_CRIT;
      st_ff.hyst <= tla_pkg::RST_HYST[4:0];
    end else begin
      st_ff <= nxt_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Each output except conv_start_out is a field of the registered state record; the start pulse comes from the timer
  always_comb begin
    rdata_out = st_ff.rdata;
    rvalid_out = st_ff.rvalid;
    conv_start_out = tick;
    remote_temp_out = st_ff.rem_temp;
    alert_req_out = st_ff.alert;
    overheat_output_out = st_ff.overheat;
  end
endmodule

// File: logic/tla_fault_queue.sv
// Out-of-limit qualifier: one hit or three in a row.
// Assumes sample_in pulses once per finished measurement.
`timescale 1ns/10ps
module tla_fault_queue (
  input wire logic mclk_in, // Core clock
  input wire logic rstn_in, // Async reset, low
  input wire logic sample_in, // Measurement done
  input wire logic over_in, // Raw out-of-limit
  input wire logic queue_in, // Three-in-a-row mode
  output logic hit_out // Qualified condition
);
  typedef struct packed {
    logic [1:0] cnt;
  } tla_fq_s;
  tla_fq_s st_ff, nxt_st;
  always_comb begin
    nxt_st = st_ff;
    if (sample_in) begin
      if (!over_in) begin
        nxt_st.cnt = 2'h0;
      end else if (st_ff.cnt != tla_pkg::QUEUE_DEPTH) begin
        nxt_st.cnt = st_ff.cnt + 2'h1;
      end
    end
  end
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign hit_out = sample_in && over_in &&
    (!queue_in || (st_ff.cnt >= tla_pkg::QUEUE_DEPTH - 2'h1));
endmodule

// File: logic/tla_pkg.sv
// Constants of the temperature limit alarm register block.
// Assumes a 100 MHz core clock and a command-byte register port.
package tla_pkg;
  localparam logic [7:0] RD_STATUS = 8'h02;
  localparam logic [7:0] RD_CONFIG = 8'h03;
  localparam logic [7:0] WR_CONFIG = 8'h09;
  localparam logic [7:0] RD_RATE = 8'h04;
  localparam logic [7:0] WR_RATE = 8'h0A;
  localparam logic [7:0] RD_LOC_HI = 8'h05;
  localparam logic [7:0] WR_LOC_HI = 8'h0B;
  localparam logic [7:0] RD_LOC_LO = 8'h06;
  localparam logic [7:0] WR_LOC_LO = 8'h0C;
  localparam logic [7:0] RD_REM_HI_H = 8'h07;
  localparam logic [7:0] WR_REM_HI_H = 8'h0D;
  localparam logic [7:0] RD_REM_LO_H = 8'h08;
  localparam logic [7:0] WR_REM_LO_H = 8'h0E;
  localparam logic [7:0] RW_OFS_H = 8'h11;
  localparam logic [7:0] RW_OFS_L = 8'h12;
  localparam logic [7:0] RW_REM_HI_L = 8'h13;
  localparam logic [7:0] RW_REM_LO_L = 8'h14;
  localparam logic [7:0] RW_REM_CRIT = 8'h19;
  localparam logic [7:0] RW_LOC_CRIT = 8'h20;
  localparam logic [7:0] RW_HYST = 8'h21;
  localparam logic [7:0] RST_RATE = 8'h08;
  localparam logic [7:0] RST_UPPER = 8'h46;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_CRIT = 8'h55;
  localparam logic [7:0] RST_HYST = 8'h0A;
  localparam logic [7:0] CFG_MASK = 8'hD5;
  localparam logic [7:0] FRAC_MASK = 8'hE0;
  localparam logic [7:0] HYST_MASK = 8'h1F;
  localparam logic [3:0] RATE_MAX = 4'h9;
  localparam int CFG_FAULTQ = 0;
  localparam int CFG_LOCAL_CRITICAL_FLAG_MASK = 2;
  localparam int CFG_REMOTE_CRITICAL_FLAG_MASK = 4;
  localparam int ST_BUSY = 7;
  localparam int ST_LOCAL_OVER_LIMIT_FLAG = 6;
  localparam int ST_LOCAL_UNDER_LIMIT_FLAG = 5;
  localparam int ST_REMOTE_OVER_LIMIT_FLAG = 4;
  localparam int ST_REMOTE_UNDER_LIMIT_FLAG = 3;
  localparam int ST_OPEN = 2;
  localparam int ST_REMOTE_CRITICAL_FLAG = 1;
  localparam int ST_LOCAL_CRITICAL_FLAG = 0;
  localparam logic [7:0] ALERT_BITS = 8'h7B;
  localparam logic [1:0] QUEUE_DEPTH = 2'h3;
  localparam int CLK_HZ = 100000000;
  localparam int FAST_HZ = 32;
  localparam int FAST_CYCLES = CLK_HZ / FAST_HZ;
endpackage

// File: logic/tla_rate_timer.sv
// Conversion interval timer: one start pulse per interval.
// Assumes a single core clock; rate code comes from the register file.
`timescale 1ns/10ps
module tla_rate_timer #(
  parameter int BASE_CYCLES = tla_pkg::FAST_CYCLES
) (
  input wire logic mclk_in, // Core clock
  input wire logic rstn_in, // Async reset, low
  input wire logic [3:0] rate_in, // Rate code
  output logic tick_out // Conversion start pulse
);
  // A base below two cycles cannot give a one-cycle start pulse
  if (BASE_CYCLES < 2) begin : g_bad_base
    $error("BASE_CYCLES too small");
  end
  typedef struct packed {
    logic [31:0] base;
    logic [9:0] div;
    logic tick;
  } tla_tmr_s;
  tla_tmr_s st_ff, nxt_st;
  logic [9:0] span;
  always_comb begin
    // Code 9 is the fastest; each lower code doubles the interval
    span = 10'(10'h001 << (tla_pkg::RATE_MAX - ((rate_in > tla_pkg::RATE_MAX) ? tla_pkg::RATE_MAX : rate_in)));
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.base >= 32'(BASE_CYCLES - 1)) begin
      nxt_st.base = 32'h0;
      if (st_ff.div >= span - 10'h001) begin
        nxt_st.div = 10'h000;
        nxt_st.tick = 1'b1;
      end else begin
        nxt_st.div = st_ff.div + 10'h001;
      end
    end else begin
      nxt_st.base = st_ff.base + 32'h1;
    end
  end
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign tick_out = st_ff.tick;
endmodule

// File: verification/tb_tla_alarm_regs.sv
// Self-checking bench of the alarm register block.
// Assumes a host model on the register port and the bench as converter.
`timescale 1ns/10ps
module tb_tla_alarm_regs;
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic conv_done_in = 1'b0;
  logic [10:0] local_temp_in = 11'h000;
  logic [10:0] remote_raw_in = 11'h000;
  logic diode_open_in = 1'b0;
  logic conv_busy_in = 1'b0;
  logic wr_en, rd_en, rvalid, start, alert, heat;
  logic [7:0] cmd, wdata, rdata;
  logic [10:0] rtemp;
  int failures = 0;
  int checks = 0;
  logic [15:0] rv [16] = '{16'h0200, 16'h0300, 16'h0408, 16'h0546, 16'h0600, 16'h0746, 16'h0800, 16'h1100,
    16'h1200, 16'h1300, 16'h1400, 16'h1955, 16'h2055, 16'h210A, 16'h3000, 16'h0B00};
  logic [31:0] wt [6] = '{32'h09FF03D5, 32'h0AFF040F, 32'h13FF13E0, 32'h21FF211F, 32'h05120546, 32'h0B500550};
  initial begin
    forever #5 mclk_in = ~mclk_in;
  end
  tla_host_model u_tla_host_model (.mclk_in(mclk_in), .wr_en_out(wr_en), .rd_en_out(rd_en), .cmd_out(cmd),
    .wdata_out(wdata), .rdata_in(rdata), .rvalid_in(rvalid));
  tla_alarm_regs #(.BASE_CYCLES(4)) u_tla_alarm_regs (.mclk_in(mclk_in), .rstn_in(rstn_in), .wr_en_in(wr_en),
    .rd_en_in(rd_en), .cmd_in(cmd), .wdata_in(wdata), .conv_done_in(conv_done_in), .local_temp_in(local_temp_in),
    .remote_raw_in(remote_raw_in), .diode_open_in(diode_open_in), .conv_busy_in(conv_busy_in),
    .rdata_out(rdata), .rvalid_out(rvalid), .conv_start_out(start), .remote_temp_out(rtemp),
    .alert_req_out(alert), .overheat_output_out(heat));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rs(input logic [7:0] c, input logic [7:0] e);
    logic [7:0] d;
    u_tla_host_model.rd(c, d);
    chk($sformatf("reg %h", c), {3'h0, e}, {3'h0, d});
  endtask
  task automatic meas(input logic [10:0] l, input logic [10:0] r);
    @(negedge mclk_in);
    local_temp_in = l;
    remote_raw_in = r;
    conv_done_in = 1'b1;
    @(negedge mclk_in);
    conv_done_in = 1'b0;
  endtask
  // Rate code to start-pulse spacing, measured from one pulse to the next
  task automatic gap(input logic [7:0] code, input logic [10:0] e);
    int n;
    n = 0;
    u_tla_host_model.wr(8'h0A, code);
    @(negedge mclk_in);
    while (start !== 1'b1) @(negedge mclk_in);
    @(negedge mclk_in);
    n = 1;
    while (start !== 1'b1) begin
      @(negedge mclk_in);
      n++;
    end
    chk("start gap", e, 11'(n));
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    finish_test();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(negedge mclk_in);
    rstn_in = 1'b1;
    for (int i = 0; i < 16; i++) rs(rv[i][15:8], rv[i][7:0]);
    for (int i = 0; i < 6; i++) begin
      u_tla_host_model.wr(wt[i][31:24], wt[i][23:16]);
      rs(wt[i][15:8], wt[i][7:0]);
    end
    u_tla_host_model.wr(8'h09, 8'h00);
    u_tla_host_model.wr(8'h21, 8'h0A);
    meas(11'h288, 11'h0C8);
    chk("alert", 11'h001, {10'h0, alert});
    rs(8'h02, 8'h40);
    rs(8'h02, 8'h00);
    chk("alert", 11'h000, {10'h0, alert});
    meas(11'h7F8, 11'h0C8);
    rs(8'h02, 8'h20);
    // Critical band is 85 down to 75 degrees with the reset hysteresis
    meas(11'h2D0, 11'h0C8);
    chk("heat", 11'h001, {10'h0, heat});
    meas(11'h280, 11'h0C8);
    chk("heat", 11'h001, {10'h0, heat});
    meas(11'h250, 11'h0C8);
    chk("heat", 11'h000, {10'h0, heat});
    rs(8'h02, 8'h41);
    u_tla_host_model.wr(8'h09, 8'h04);
    meas(11'h2D0, 11'h0C8);
    chk("heat", 11'h000, {10'h0, heat});
    meas(11'h250, 11'h0C8);
    rs(8'h02, 8'h41);
    u_tla_host_model.wr(8'h09, 8'h00);
    u_tla_host_model.wr(8'h11, 8'h02);
    meas(11'h0C8, 11'h228);
    chk("remote", 11'h238, rtemp);
    rs(8'h02, 8'h10);
    meas(11'h0C8, 11'h7D8);
    rs(8'h02, 8'h08);
    meas(11'h0C8, 11'h2D0);
    rs(8'h02, 8'h12);
    meas(11'h0C8, 11'h0C8);
    u_tla_host_model.wr(8'h09, 8'h01);
    meas(11'h0C8, 11'h280);
    meas(11'h0C8, 11'h280);
    rs(8'h02, 8'h00);
    meas(11'h0C8, 11'h280);
    rs(8'h02, 8'h10);
    diode_open_in = 1'b1;
    conv_busy_in = 1'b1;
    repeat (4) @(negedge mclk_in);
    rs(8'h02, 8'h84);
    chk("alert", 11'h000, {10'h0, alert});
    // Base of 4 cycles is code 9; each lower code doubles, codes above 9 act as 9
    gap(8'h07, 11'h010);
    gap(8'h0C, 11'h004);
    finish_test();
  end
endmodule

// File: verification/tla_alarm_checker.sv
// Port-level checks of the alarm register block.
// Assumes one core clock and async low reset; bound to every instance.
`timescale 1ns/10ps
module tla_alarm_checker #(
  parameter int BASE_CYCLES = 4
) (
  input wire logic mclk_in, // Core clock
  input wire logic rstn_in, // Reset, low
  input wire logic wr_en_in, // Write strobe
  input wire logic rd_en_in, // Read strobe
  input wire logic [7:0] cmd_in, // Command byte
  input wire logic conv_done_in, // Result valid
  input wire logic [7:0] rdata_out, // Read data
  input wire logic rvalid_out, // Read valid
  input wire logic conv_start_out, // Start pulse
  input wire logic [10:0] remote_temp_out, // Corrected reading
  input wire logic alert_req_out, // Alert request
  input wire logic overheat_output_out // Critical output
);
  logic st_rd;
  assign st_rd = rd_en_in && (cmd_in == 8'h02);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rstn_in);
  //////////////////////////////////////////////////////////////////////////////
  a_read_answer: assert property (rd_en_in |=> rvalid_out)
    else $error("read not answered");
  a_no_stray_valid: assert property (!rd_en_in |=> !rvalid_out)
    else $error("read valid without read");
  a_rdata_holds: assert property (!rd_en_in |=> $stable(rdata_out))
    else $error("read data moved without read");
  a_temp_holds: assert property (!conv_done_in |=> $stable(remote_temp_out))
    else $error("remote reading moved without result");
  a_alert_cause: assert property ($rose(alert_req_out) |-> $past(conv_done_in))
    else $error("alert rose without result");
  a_alert_sticky: assert property ($fell(alert_req_out) |-> $past(st_rd))
    else $error("alert fell without status read");
  a_status_clears: assert property (st_rd && !conv_done_in |=> !alert_req_out)
    else $error("alert kept after status read");
  a_heat_cause: assert property ($rose(overheat_output_out) |-> $past(conv_done_in) || $past(wr_en_in))
    else $error("overheat rose without cause");
  a_start_gap: assert property (conv_start_out |=> !conv_start_out [*3])
    else $error("start pulses too close");
  c_status_read: cover property (st_rd ##1 rvalid_out);
  c_alert: cover property ($rose(alert_req_out));
  c_heat: cover property ($fell(overheat_output_out));
  c_start: cover property (conv_start_out);
endmodule
bind tla_alarm_regs tla_alarm_checker #(.BASE_CYCLES(BASE_CYCLES)) u_tla_alarm_checker (
  .mclk_in(mclk_in), .rstn_in(rstn_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .cmd_in(cmd_in),
  .conv_done_in(conv_done_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
  .conv_start_out(conv_start_out), .remote_temp_out(remote_temp_out), .alert_req_out(alert_req_out),
  .overheat_output_out(overheat_output_out));

// File: verification/tla_host_model.sv
// Host side of the command-byte register port.
// Assumes requests change at the falling edge and are taken at the rising one.
`timescale 1ns/10ps
module tla_host_model (
  input wire logic mclk_in, // Core clock
  output logic wr_en_out, // Write strobe
  output logic rd_en_out, // Read strobe
  output logic [7:0] cmd_out, // Command byte
  output logic [7:0] wdata_out, // Write data
  input wire logic [7:0] rdata_in, // Read data
  input wire logic rvalid_in // Read valid
);
  initial begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    cmd_out = 8'hFF;
    wdata_out = 8'hFF;
  end
  // Released lines show the inverse so a stale value is never taken
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    @(negedge mclk_in);
    wr_en_out = 1'b1;
    cmd_out = c;
    wdata_out = d;
    @(negedge mclk_in);
    wr_en_out = 1'b0;
    cmd_out = ~c;
    wdata_out = ~d;
  endtask
  // Callers leave a conversion's time before reading status after a start
  task automatic rd(input logic [7:0] c, output logic [7:0] d);
    @(negedge mclk_in);
    rd_en_out = 1'b1;
    cmd_out = c;
    @(negedge mclk_in);
    rd_en_out = 1'b0;
    cmd_out = ~c;
    d = (rvalid_in === 1'b1) ? rdata_in : 8'hXX;
  endtask
endmodule
